// ---- rtl/ahp_pkg.sv ----
// Package: register map, field positions, reset values and timing for the alert and hot-pin block
package ahp_pkg;

  // Register offsets
  localparam logic [7:0] ADDR_STATUS_ONE  = 8'h41;
  localparam logic [7:0] ADDR_STATUS_TWO  = 8'h42;
  localparam logic [7:0] ADDR_MASK_ONE    = 8'h74;
  localparam logic [7:0] ADDR_MASK_TWO    = 8'h75;
  localparam logic [7:0] ADDR_PIN_FULL_SPEED_ON_HOT   = 8'h78;
  localparam logic [7:0] ADDR_TIMER       = 8'h79;
  localparam logic [7:0] ADDR_TIMER_LIMIT = 8'h7a;
  localparam logic [7:0] ADDR_PIN_FUNC    = 8'h7d;

  // Reset values
  localparam logic [7:0] RST_MASK_ONE    = 8'h00;
  localparam logic [7:0] RST_MASK_TWO    = 8'h00;
  localparam logic [7:0] RST_PIN_FULL_SPEED_ON_HOT   = 8'h00;
  localparam logic [7:0] RST_TIMER_LIMIT = 8'h00;
  localparam logic [7:0] RST_PIN_FUNC    = 8'h00;

  // Status one fields
  localparam int S1_SUMMARY = 7;
  localparam int S1_SUPPLY25 = 0;
  // Status two fields
  localparam int S2_FAN4_HOT = 5;
  localparam int S2_SUPPLY12 = 0;

  // Pin and full_speed_on_hot configuration fields
  localparam int CFG3_ALERT_PIN10 = 0;
  localparam int CFG3_HOT_ENABLE  = 1;
  localparam int CFG3_FULL_SPEED_ON_HOT       = 2;

  // Shared pin function field, value is {bit1, bit0}
  localparam int          CFG4_FUNC_LSB = 0;
  localparam logic [1:0]  FUNC_FOURTH_TACH = 2'b00;
  localparam logic [1:0]  FUNC_HOT         = 2'b10;
  localparam logic [1:0]  FUNC_ALERT       = 2'b01;
  localparam logic [1:0]  FUNC_IO_SIX      = 2'b11;

  // Hot-pin timer resolution
  localparam int CLK_MHZ       = 200;
  localparam int TIMER_LSB_US  = 22760;
  localparam int TIMER_LSB_CYC = TIMER_LSB_US * CLK_MHZ;
  localparam int TIMER_MAX     = 8'hFF;

  // Live out-of-limit conditions from the comparators
  typedef struct packed {
    logic remote2_temp_flag;
    logic local_temp_flag;
    logic remote1_temp_flag;
    logic supply5_flag;
    logic supply_flag;
    logic core_supply_flag;
    logic supply25_flag;
    logic diode2_fault_flag;
    logic diode1_fault_flag;
    logic fan4_slow_flag;
    logic fan_three_slow_flag;
    logic fan_two_slow_flag;
    logic fan_one_slow_flag;
    logic overtemp_flag;
    logic supply12_flag;
  } ahp_cond_s;

  // Register access port
  typedef struct packed {
    logic [7:0] addr;
    logic       wr;
    logic       rd;
    logic [7:0] wdata;
  } ahp_req_s;

endpackage

// ---- rtl/ahp_top.sv ----
// Alert status, masking, pin-function selection and hot-pin timer
`timescale 1ns/1ps

// Summary of operation
// RQ1: Status one bit 7 is set whenever any status two bit is set.
// RQ2: Status one bits 6..0 flag temperature and supply limit violations.
// RQ3: With hot pin enabled, status one bit 0 reports hot-pin timer status.
// RQ4: Status two bits 7 and 6 flag remote diode two and one faults.
// RQ5: Status two bits 4, 3, 2 flag fans 3, 2, 1 under speed.
// RQ6: Status two bit 1 flags any overtemperature limit exceeded.
// RQ7: Status two bit 5 is fan 4, hot timer or GPIO six per pin function.
// RQ8: Status two bit 0 is 12 V violation or voltage-identification change.
// RQ9: Status bits are sticky until condition gone and register read.
// RQ10: Alert stays low while unmasked source out of limit and until read.
// RQ11: Masks gate only the alert, never the status bits.
// RQ12: Mask one mirrors status one; its bit 7 masks all of status two.
// RQ13: Mask two mirrors status two bit for bit.
// RQ14: Alert off after reset; config three bit 0 picks alert or fan drive.
// RQ15: Config four bits 1..0 pick fourth tachometer, hot pin, alert or GPIO six.
// RQ16: Hot enable makes the 2.5 V pin the hot pin and allows pin 14 hot.
// RQ17: With full_speed_on_hot set, fans run full while the hot pin is low.
// RQ18: Full_speed_on_hot applies only to fans already running.
// RQ19: Timer counts only while asserted, pauses, resumes without clearing.
// RQ20: Timer clears on read and saturates at full scale.
// RQ21: Timer bit 0 set on first assertion; LSB worth 22.76 ms afterwards.
// RQ22: Read during assertion clears, sets bit 0 again, counts from zero.
// RQ23: Host reads status two after the timer to clear bit 5.
// RQ24: Host masks the source on alert and unmasks once status clears.
// RQ25: Timer above limit sets the hot timer status bit.
// RQ26: A read in the same cycle as a live condition leaves the bit set.
// RQ27: Alert is the OR of unmasked status bits, driven only when selected.
module ahp_top
  import ahp_pkg::*;
#(
  parameter int TICK_CYCLES = TIMER_LSB_CYC
) (
  input  wire logic       core_clk_i,
  input  wire logic       reset_i,
  input  wire ahp_req_s   reg_req_i,
  output logic [7:0]      reg_rdata_o,
  input  wire ahp_cond_s  cond_i,
  input  wire logic       vid_change_sel_i,
  input  wire logic [5:0] vid_i,
  input  wire logic       hot_pin22_n_i,
  input  wire logic       pin14_i,
  output logic            pin14_o,
  output logic            pin14_oe_o,
  input  wire logic       second_fan_drive_i,
  output logic            pin10_o,
  output logic            pin10_oe_o,
  input  wire logic [7:0] manual_duty_i,
  input  wire logic       auto_mode_i,
  input  wire logic       temp_above_start_i,
  output logic            full_speed_o
);

  logic [7:0]  mask1_q;
  logic [7:0]  mask2_q;
  logic [7:0]  cfg3_q;
  logic [7:0]  limit_q;
  logic [7:0]  cfg4_q;
  logic [6:0]  st1_q;
  logic [6:0]  st1_d;
  logic [7:0]  st2_q;
  logic [7:0]  st2_d;
  logic [7:0]  units_q;
  logic [7:0]  units_d;
  logic        seen_q;
  logic        seen_d;
  logic [31:0] pre_q;
  logic [31:0] pre_d;
  logic [7:0]  rdata_q;
  logic [7:0]  rdata_d;
  logic [5:0]  vid_s1_q;
  logic [5:0]  vid_s2_q;
  logic [5:0]  vid_prev_q;
  logic        vid_valid_q;
  logic        p22_s1_q;
  logic        p22_s2_q;
  logic        p14_s1_q;
  logic        p14_s2_q;

  // Shared address compare for the read strobes and the register writes
  function automatic logic addr_is(input logic [7:0] a, input logic [7:0] target);
    return a == target;
  endfunction

  // Address decode
  wire         hit_st1   = addr_is(reg_req_i.addr, ADDR_STATUS_ONE);
  wire         hit_st2   = addr_is(reg_req_i.addr, ADDR_STATUS_TWO);
  wire         hit_timer = addr_is(reg_req_i.addr, ADDR_TIMER);
  wire         wr_mask1  = reg_req_i.wr && addr_is(reg_req_i.addr, ADDR_MASK_ONE);
  wire         wr_mask2  = reg_req_i.wr && addr_is(reg_req_i.addr, ADDR_MASK_TWO);
  wire         wr_cfg3   = reg_req_i.wr && addr_is(reg_req_i.addr, ADDR_PIN_FULL_SPEED_ON_HOT);
  wire         wr_limit  = reg_req_i.wr && addr_is(reg_req_i.addr, ADDR_TIMER_LIMIT);
  wire         wr_cfg4   = reg_req_i.wr && addr_is(reg_req_i.addr, ADDR_PIN_FUNC);
  wire         rd_st1    = reg_req_i.rd && hit_st1;
  wire         rd_st2    = reg_req_i.rd && hit_st2;
  wire         rd_timer  = reg_req_i.rd && hit_timer;

  // Pin function selection
  wire [1:0]   pin14_func = cfg4_q[CFG4_FUNC_LSB +: 2];                     // see RQ15
  wire         hot_en     = cfg3_q[CFG3_HOT_ENABLE];
  wire         p14_hot    = hot_en && (pin14_func == FUNC_HOT);             // see RQ16
  wire         p14_gpio   = pin14_func == FUNC_IO_SIX;
  wire         p14_alert  = pin14_func == FUNC_ALERT;
  wire         p10_alert  = cfg3_q[CFG3_ALERT_PIN10];                       // see RQ14

  // Hot pins are active low
  wire         hot22_act  = hot_en && !p22_s2_q;                            // see RQ16
  wire         hot14_act  = p14_hot && !p14_s2_q;
  wire         hot_active = hot22_act || hot14_act;

  // Timer value: bit 0 alone until the first whole LSB has accrued
  wire [7:0]   timer_val  = (units_q == 8'h00) ? {7'h00, seen_q} : units_q; // see RQ21
  wire         limit_hit  = timer_val > limit_q;                            // see RQ25
  wire         tick       = hot_active && (pre_q == 32'(TICK_CYCLES - 1));

  wire         vid_change = vid_valid_q && (vid_s2_q != vid_prev_q);

  // Live sources, in register bit order
  wire         src_fan4   = p14_gpio ? p14_s2_q :                           // see RQ7
                            p14_hot  ? limit_hit : cond_i.fan4_slow_flag;
  wire         src_b0     = hot_en ? limit_hit : cond_i.supply25_flag;      // see RQ3
  wire         src_12     = vid_change_sel_i ? vid_change : cond_i.supply12_flag; // see RQ8
  wire [6:0]   src1 = {cond_i.remote2_temp_flag, cond_i.local_temp_flag,    // see RQ2
                       cond_i.remote1_temp_flag, cond_i.supply5_flag,
                       cond_i.supply_flag, cond_i.core_supply_flag, src_b0};
  wire [7:0]   src2 = {cond_i.diode2_fault_flag, cond_i.diode1_fault_flag,  // see RQ4
                       src_fan4, cond_i.fan_three_slow_flag,                // see RQ5
                       cond_i.fan_two_slow_flag, cond_i.fan_one_slow_flag,
                       cond_i.overtemp_flag, src_12};                       // see RQ6

  // Status one with summary bit derived from status two
  wire [7:0]   st1_val = {|st2_q, st1_q};                                   // see RQ1

  // Masks gate only the alert, not the status bits themselves
  wire         alert1 = |(st1_q & ~mask1_q[6:0]);                           // see RQ12
  wire         alert2 = !mask1_q[S1_SUMMARY] && |(st2_q & ~mask2_q);        // see RQ13
  wire         alert  = alert1 || alert2;                                   // see RQ27

  // Full_speed_on_hot only for a fan already turning
  wire         fan_running = auto_mode_i ? temp_above_start_i :            // see RQ18
                             (manual_duty_i != 8'h00);

  // Sticky status: a live source wins over the read-clear
  assign st1_d = src1 | (st1_q & {7{!rd_st1}});                            // see RQ9 RQ26 RQ11
  assign st2_d = src2 | (st2_q & {8{!rd_st2}});                            // see RQ9 RQ26 RQ11

  // Timer: count while asserted, hold otherwise, clear on read
  always_comb begin
    units_d = units_q;
    seen_d  = seen_q || hot_active;                                        // see RQ21
    pre_d   = pre_q;
    if (rd_timer) begin
      units_d = 8'h00;                                                     // see RQ20
      seen_d  = hot_active;                                                // see RQ22
      pre_d   = 32'h0000_0000;
    end else if (hot_active) begin
      if (tick) begin
        pre_d = 32'h0000_0000;
        if (units_q != 8'(TIMER_MAX)) begin
          units_d = units_q + 8'h01;                                       // see RQ20
        end
      end else begin
        pre_d = pre_q + 32'h0000_0001;                                     // see RQ19
      end
    end
  end

  // Read data mux
  always_comb begin
    case (reg_req_i.addr)
      ADDR_STATUS_ONE:  rdata_d = st1_val;
      ADDR_STATUS_TWO:  rdata_d = st2_q;
      ADDR_MASK_ONE:    rdata_d = mask1_q;
      ADDR_MASK_TWO:    rdata_d = mask2_q;
      ADDR_PIN_FULL_SPEED_ON_HOT:   rdata_d = cfg3_q;
      ADDR_TIMER:       rdata_d = timer_val;
      ADDR_TIMER_LIMIT: rdata_d = limit_q;
      ADDR_PIN_FUNC:    rdata_d = cfg4_q;
      default:          rdata_d = 8'h00;
    endcase
  end

  // Synchronisers for pins
  always_ff @(posedge core_clk_i) begin
    vid_s1_q <= vid_i;
    vid_s2_q <= vid_s1_q;
    p22_s1_q <= hot_pin22_n_i;
    p22_s2_q <= p22_s1_q;
    p14_s1_q <= pin14_i;
    p14_s2_q <= p14_s1_q;
  end

  // Configuration registers
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      mask1_q <= RST_MASK_ONE;
      mask2_q <= RST_MASK_TWO;
      cfg3_q  <= RST_PIN_FULL_SPEED_ON_HOT;
      limit_q <= RST_TIMER_LIMIT;
      cfg4_q  <= RST_PIN_FUNC;
    end else begin
      if (wr_mask1) mask1_q <= reg_req_i.wdata;
      if (wr_mask2) mask2_q <= reg_req_i.wdata;
      if (wr_cfg3)  cfg3_q  <= reg_req_i.wdata;
      if (wr_limit) limit_q <= reg_req_i.wdata;
      if (wr_cfg4)  cfg4_q  <= reg_req_i.wdata;
    end
  end

  // Status, timer and read data
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      st1_q       <= 7'h00;
      st2_q       <= 8'h00;
      units_q     <= 8'h00;
      seen_q      <= 1'b0;
      pre_q       <= 32'h0000_0000;
      rdata_q     <= 8'h00;
      vid_prev_q  <= 6'h00;
      vid_valid_q <= 1'b0;
    end else begin
      st1_q       <= st1_d;
      st2_q       <= st2_d;
      units_q     <= units_d;
      seen_q      <= seen_d;
      pre_q       <= pre_d;
      rdata_q     <= reg_req_i.rd ? rdata_d : rdata_q;
      vid_prev_q  <= vid_s2_q;
      vid_valid_q <= 1'b1;
    end
  end

  assign reg_rdata_o  = rdata_q;
  // Open-drain alert; fan drive is push-pull when pin 10 is not the alert
  assign pin10_o      = p10_alert ? 1'b0 : second_fan_drive_i;              // see RQ14
  assign pin10_oe_o   = p10_alert ? alert : 1'b1;                           // see RQ10
  assign pin14_o      = 1'b0;
  assign pin14_oe_o   = p14_alert && alert;                                 // see RQ27
  assign full_speed_o = cfg3_q[CFG3_FULL_SPEED_ON_HOT] && hot_active && fan_running;    // see RQ17

  // Checks
  summary_bit_a: assert property (@(posedge core_clk_i) disable iff (reset_i) // see RQ1
    rd_st1 |=> reg_rdata_o[S1_SUMMARY] == $past(|st2_q))
    else $error("summary bit does not follow status two");

  sticky_hold_a: assert property (@(posedge core_clk_i) disable iff (reset_i) // see RQ9
    !rd_st2 |=> (st2_q & $past(st2_q)) == $past(st2_q))
    else $error("status two bit lost without a read");

  read_clear_a: assert property (@(posedge core_clk_i) disable iff (reset_i) // see RQ9
    rd_st2 && (src2 == 8'h00) |=> st2_q == 8'h00)
    else $error("status two not cleared by read");

  set_wins_a: assert property (@(posedge core_clk_i) disable iff (reset_i) // see RQ26
    rd_st1 |=> (st1_q & $past(src1)) == $past(src1))
    else $error("live source lost on status one read");

  mask_status_a: assert property (@(posedge core_clk_i) disable iff (reset_i) // see RQ11
    (src2 & mask2_q) != 8'h00 |=> (st2_q & $past(mask2_q & src2)) != 8'h00)
    else $error("masked source did not set status");

  alert_drive_a: assert property (@(posedge core_clk_i) disable iff (reset_i) // see RQ10
    p10_alert && (st1_q & ~mask1_q[6:0]) != 7'h00 |-> pin10_oe_o && !pin10_o)
    else $error("alert not driven low for unmasked status");

  alert_reset_a: assert property (@(posedge core_clk_i) // see RQ14
    $past(reset_i) |-> pin10_oe_o && !pin14_oe_o)
    else $error("alert function active after reset");

  timer_pause_a: assert property (@(posedge core_clk_i) disable iff (reset_i) // see RQ19
    !hot_active && !rd_timer |=> $stable(units_q) && $stable(pre_q))
    else $error("timer moved while hot pin idle");

  timer_read_a: assert property (@(posedge core_clk_i) disable iff (reset_i) // see RQ22
    rd_timer && hot_active |=> timer_val == 8'h01)
    else $error("timer read during assertion not restarted");

  timer_sat_a: assert property (@(posedge core_clk_i) disable iff (reset_i) // see RQ20
    units_q == 8'hFF && !rd_timer |=> units_q == 8'hFF)
    else $error("timer left full scale without read");

  limit_flag_a: assert property (@(posedge core_clk_i) disable iff (reset_i) // see RQ25
    p14_hot && limit_hit |=> st2_q[S2_FAN4_HOT])
    else $error("timer limit did not set status bit");

  full_speed_on_hot_idle_a: assert property (@(posedge core_clk_i) disable iff (reset_i) // see RQ18
    !auto_mode_i && manual_duty_i == 8'h00 |-> !full_speed_o)
    else $error("full_speed_on_hot on a stopped fan");

  // Status set and clear paths
  st_one_set_a: assert property (@(posedge core_clk_i) disable iff (reset_i) // see RQ2
    src1 != 7'h00 |=> (st1_q & $past(src1)) == $past(src1))
    else $error("status one source not latched");

  diode_fault_a: assert property (@(posedge core_clk_i) disable iff (reset_i) // see RQ4
    cond_i.diode2_fault_flag |=> st2_q[7])
    else $error("diode fault not flagged");

  fan_slow_a: assert property (@(posedge core_clk_i) disable iff (reset_i) // see RQ5
    cond_i.fan_three_slow_flag |=> st2_q[4])
    else $error("slow fan not flagged");

  overtemp_set_a: assert property (@(posedge core_clk_i) disable iff (reset_i) // see RQ6
    cond_i.overtemp_flag |=> st2_q[1])
    else $error("overtemperature not flagged");

  hot_bit0_a: assert property (@(posedge core_clk_i) disable iff (reset_i) // see RQ3
    hot_en && limit_hit |=> st1_q[S1_SUPPLY25])
    else $error("hot status missing in bit 0");

  io_six_status_a: assert property (@(posedge core_clk_i) disable iff (reset_i) // see RQ7
    p14_gpio && p14_s2_q |=> st2_q[S2_FAN4_HOT])
    else $error("general io level not flagged");

  vid_change_a: assert property (@(posedge core_clk_i) disable iff (reset_i) // see RQ8
    vid_change_sel_i && vid_change |=> st2_q[S2_SUPPLY12])
    else $error("code change not flagged");

  status_clear_a: assert property (@(posedge core_clk_i) disable iff (reset_i) // see RQ9
    rd_st1 && src1 == 7'h00 |=> st1_q == 7'h00)
    else $error("status one not cleared by read");

  masked_set_a: assert property (@(posedge core_clk_i) disable iff (reset_i) // see RQ11
    (src1 & mask1_q[6:0]) != 7'h00 |=> st1_q != 7'h00)
    else $error("masked source did not set status one");

  // Alert and pin selection
  alert_release_a: assert property (@(posedge core_clk_i) disable iff (reset_i) // see RQ10
    p10_alert && !alert |-> !pin10_oe_o)
    else $error("alert held with nothing pending");

  summary_mask_a: assert property (@(posedge core_clk_i) disable iff (reset_i) // see RQ12
    mask1_q[S1_SUMMARY] && (st1_q & ~mask1_q[6:0]) == 7'h00
    |-> !pin14_oe_o && !(p10_alert && pin10_oe_o))
    else $error("status two alert not masked");

  mask_two_a: assert property (@(posedge core_clk_i) disable iff (reset_i) // see RQ13
    p14_alert && !mask1_q[S1_SUMMARY] && (st2_q & ~mask2_q) != 8'h00 |-> pin14_oe_o)
    else $error("unmasked status two gave no alert");

  fan_drive_a: assert property (@(posedge core_clk_i) disable iff (reset_i) // see RQ14
    !p10_alert |-> pin10_oe_o && pin10_o == second_fan_drive_i)
    else $error("fan drive not passed to pin");

  pin_select_a: assert property (@(posedge core_clk_i) disable iff (reset_i) // see RQ15
    !p14_alert |-> !pin14_oe_o)
    else $error("shared pin driven in wrong function");

  hot_disable_a: assert property (@(posedge core_clk_i) disable iff (reset_i) // see RQ16
    !hot_en |-> !hot_active)
    else $error("hot input active while disabled");

  full_speed_on_hot_hot_a: assert property (@(posedge core_clk_i) disable iff (reset_i) // see RQ17
    cfg3_q[CFG3_FULL_SPEED_ON_HOT] && hot_active && fan_running |-> full_speed_o)
    else $error("no full speed on hot input");

  alert_or_a: assert property (@(posedge core_clk_i) disable iff (reset_i) // see RQ27
    !alert |-> !pin14_oe_o && !(p10_alert && pin10_oe_o))
    else $error("alert pin pulled without a source");

  // Hot timer
  timer_step_a: assert property (@(posedge core_clk_i) disable iff (reset_i) // see RQ19
    tick && !rd_timer && units_q != 8'hFF |=> units_q == $past(units_q) + 8'h01)
    else $error("timer missed a unit");

  timer_clear_a: assert property (@(posedge core_clk_i) disable iff (reset_i) // see RQ20
    rd_timer && !hot_active |=> timer_val == 8'h00)
    else $error("timer not cleared by read");

  timer_first_a: assert property (@(posedge core_clk_i) disable iff (reset_i) // see RQ21
    hot_active && !rd_timer && timer_val == 8'h00 |=> timer_val == 8'h01)
    else $error("first assertion did not set bit 0");

endmodule

// ---- bench/ahp_host_model.sv ----
// Host partner model: register strobes, read collection and alert service
`timescale 1ns/1ps
module ahp_host_model
  import ahp_pkg::*;
(
  input  wire logic       core_clk_i,
  input  wire logic [7:0] reg_rdata_i,
  output ahp_req_s        reg_req_o
);
  logic [7:0] m1 = 8'h00;
  logic [7:0] m2 = 8'h00;
  logic [7:0] s1;
  logic [7:0] s2;
  initial reg_req_o = '0;
  task automatic issue(input logic [7:0] a, input logic w, input logic [7:0] v);
    @(posedge core_clk_i) reg_req_o <= '{addr: a, wr: w, rd: !w, wdata: v};
    // Idle address and data keep moving so stale values are never mistaken for a request
    @(posedge core_clk_i) reg_req_o <= '{addr: ~a, wr: 1'b0, rd: 1'b0, wdata: ~v};
  endtask
  task automatic write_reg(input logic [7:0] a, input logic [7:0] v);
    issue(a, 1'b1, v);
  endtask
  task automatic read_reg(input logic [7:0] a, output logic [7:0] v);
    issue(a, 1'b0, 8'h00);
    #1 v = reg_rdata_i;
  endtask
  // Find the sources and mask them so the alert stops holding the host up
  task automatic mask_alert();
    read_reg(ADDR_STATUS_ONE, m1);
    read_reg(ADDR_STATUS_TWO, m2);
    write_reg(ADDR_MASK_ONE, m1);
    write_reg(ADDR_MASK_TWO, m2);
  endtask
  // A mask is lifted only once its status bit has cleared
  task automatic poll_unmask();
    read_reg(ADDR_STATUS_ONE, s1);
    read_reg(ADDR_STATUS_TWO, s2);
    m1 = m1 & s1;
    m2 = m2 & s2;
    write_reg(ADDR_MASK_ONE, m1);
    write_reg(ADDR_MASK_TWO, m2);
  endtask
  task automatic read_timer(output logic [7:0] t, output logic [7:0] st);
    read_reg(ADDR_TIMER, t);
    read_reg(ADDR_STATUS_TWO, st);
  endtask
endmodule

// ---- bench/tb.sv ----
// Self-checking testbench for the alert status and hot-pin timer block
`timescale 1ns/1ps
module tb
  import ahp_pkg::*;
;
  localparam int TICK = 4;
  logic       clk = 1'b0;
  logic       rst = 1'b1;
  ahp_req_s   req;
  ahp_cond_s  cond = '0;
  logic       vsel = 1'b0;
  logic [5:0] voltage_identification_inputs = 6'h00;
  logic       hot_n = 1'b1;
  logic       p14 = 1'b1;
  logic       fan_drv = 1'b0;
  logic [7:0] duty = 8'h00;
  logic       auto_m = 1'b0;
  logic       above = 1'b0;
  logic       p14_o, p14_oe, p10_o, p10_oe, full;
  logic [7:0] rdata, d, st;
  int         err_count = 0;
  int         num_checks = 0;
  int         cyc = 0;
  int         n1, n2;
  logic [7:0] ra [9] = '{ADDR_MASK_ONE, ADDR_MASK_TWO, ADDR_PIN_FULL_SPEED_ON_HOT, ADDR_TIMER_LIMIT,
                         ADDR_PIN_FUNC, ADDR_STATUS_ONE, ADDR_STATUS_TWO, ADDR_TIMER, 8'h50};

  initial forever #2.5 clk = ~clk;

  ahp_top #(.TICK_CYCLES(TICK)) u_dut (
    .core_clk_i(clk), .reset_i(rst), .reg_req_i(req), .reg_rdata_o(rdata), .cond_i(cond),
    .vid_change_sel_i(vsel), .vid_i(voltage_identification_inputs), .hot_pin22_n_i(hot_n), .pin14_i(p14),
    .pin14_o(p14_o), .pin14_oe_o(p14_oe), .second_fan_drive_i(fan_drv), .pin10_o(p10_o),
    .pin10_oe_o(p10_oe), .manual_duty_i(duty), .auto_mode_i(auto_m),
    .temp_above_start_i(above), .full_speed_o(full)
  );
  ahp_host_model u_host (.core_clk_i(clk), .reg_rdata_i(rdata), .reg_req_o(req));

  // Status image of one pulsed source, by its index in the condition vector
  function automatic logic [7:0] sexp(input int i, input bit two);
    if (two) return (i < 8) ? 8'(1 << i) : 8'h00;
    return (i < 8) ? 8'h80 : 8'(1 << (i - 8));
  endfunction
  function automatic logic [7:0] texp(input int c);
    int u;
    u = c / TICK;
    return (u == 0) ? 8'h01 : ((u > 255) ? 8'hFF : 8'(u));
  endfunction
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    num_checks++;
    if (got !== exp) begin
      $display("wrong value at %0t ns: %s got %h expected %h", $time, what, got, exp);
      err_count++;
    end
  endtask
  task automatic rc(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] v;
    u_host.read_reg(a, v);
    chk(v, e, $sformatf("register %h", a));
  endtask
  task automatic pulse(input ahp_cond_s c);
    @(posedge clk) cond <= c;
    @(posedge clk) cond <= '0;
    repeat (2) @(posedge clk);
    #1;
  endtask
  // Four idle cycles after release let the pin synchroniser drain
  task automatic hot(input int n, input bit on14);
    @(posedge clk) {p14, hot_n} <= on14 ? 2'b01 : 2'b10;
    repeat (n) @(posedge clk);
    {p14, hot_n} <= 2'b11;
    repeat (4) @(posedge clk);
  endtask
  task automatic fs(input logic [7:0] du, input logic au, input logic ab, input logic e);
    @(posedge clk) duty <= du;
    auto_m <= au;
    above <= ab;
    @(posedge clk) #1 chk({7'h0, full}, {7'h0, e}, "full speed");
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      report_and_stop();
    end
  end

  initial begin
    void'($urandom(32'he0d4_3951));
    fan_drv <= 1'($urandom);
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    foreach (ra[i]) rc(ra[i], 8'h00);
    chk({6'h0, p10_o, p10_oe}, {6'h0, fan_drv, 1'b1}, "pin10 fan drive");
    for (int i = 0; i < 5; i++) begin
      d = 8'($urandom);
      u_host.write_reg(ra[i], d);
      rc(ra[i], d);
      u_host.write_reg(ra[i], 8'h00);
    end
    u_host.read_reg(ADDR_STATUS_TWO, d);
    u_host.write_reg(ADDR_STATUS_TWO, 8'hFF);
    rc(ADDR_STATUS_TWO, 8'h00);
    $display("test registers done");
    for (int i = 0; i < 15; i++) begin
      pulse(ahp_cond_s'(15'(1) << i));
      rc(ADDR_STATUS_ONE, sexp(i, 1'b0));
      rc(ADDR_STATUS_TWO, sexp(i, 1'b1));
      rc(ADDR_STATUS_ONE, 8'h00);
      rc(ADDR_STATUS_TWO, 8'h00);
    end
    $display("test sticky status done");
    u_host.write_reg(ADDR_PIN_FULL_SPEED_ON_HOT, 8'h01);
    @(posedge clk) cond.local_temp_flag <= 1'b1;
    repeat (2) @(posedge clk);
    #1 chk({6'h0, p10_o, p10_oe}, 8'h01, "alert on");
    rc(ADDR_STATUS_ONE, 8'h20);
    rc(ADDR_STATUS_ONE, 8'h20);
    u_host.mask_alert();
    #1 chk({7'h0, p10_oe}, 8'h00, "masked alert");
    rc(ADDR_STATUS_ONE, 8'h20);
    @(posedge clk) cond <= '0;
    u_host.poll_unmask();
    u_host.poll_unmask();
    rc(ADDR_MASK_ONE, 8'h00);
    #1 chk({7'h0, p10_oe}, 8'h00, "alert after service");
    pulse(ahp_cond_s'(15'h0040));
    chk({7'h0, p10_oe}, 8'h01, "alert held");
    u_host.write_reg(ADDR_MASK_ONE, 8'h80);
    #1 chk({7'h0, p10_oe}, 8'h00, "summary mask");
    u_host.write_reg(ADDR_MASK_ONE, 8'h00);
    u_host.write_reg(ADDR_MASK_TWO, 8'h40);
    #1 chk({7'h0, p10_oe}, 8'h00, "mask two");
    u_host.write_reg(ADDR_MASK_TWO, 8'h00);
    #1 chk({7'h0, p10_oe}, 8'h01, "unmasked");
    rc(ADDR_STATUS_TWO, 8'h40);
    chk({7'h0, p10_oe}, 8'h00, "alert after read");
    u_host.write_reg(ADDR_PIN_FULL_SPEED_ON_HOT, 8'h00);
    u_host.write_reg(ADDR_PIN_FUNC, {6'h00, FUNC_ALERT});
    pulse(ahp_cond_s'(15'h0001));
    chk({4'h0, p14_o, p14_oe, p10_o, p10_oe}, {6'h01, fan_drv, 1'b1}, "pin14");
    rc(ADDR_STATUS_TWO, 8'h01);
    chk({7'h0, p14_oe}, 8'h00, "pin14 released");
    $display("test alert done");
    u_host.write_reg(ADDR_PIN_FUNC, 8'h00);
    u_host.write_reg(ADDR_PIN_FULL_SPEED_ON_HOT, 8'h02);
    n1 = 4 * int'($urandom_range(2)) + 1;
    n2 = 4 * int'($urandom_range(2)) + 1;
    hot(n1, 1'b0);
    hot(n2, 1'b0);
    rc(ADDR_TIMER, texp(n1 + n2));
    rc(ADDR_TIMER, 8'h00);
    rc(ADDR_STATUS_ONE, 8'h01);
    rc(ADDR_STATUS_ONE, 8'h00);
    u_host.write_reg(ADDR_TIMER_LIMIT, 8'h01);
    hot(5, 1'b0);
    rc(ADDR_STATUS_ONE, 8'h00);
    rc(ADDR_TIMER, 8'h01);
    hot(9, 1'b0);
    rc(ADDR_STATUS_ONE, 8'h01);
    rc(ADDR_TIMER, 8'h02);
    hot(1200, 1'b0);
    rc(ADDR_TIMER, 8'hFF);
    u_host.write_reg(ADDR_TIMER_LIMIT, 8'h00);
    @(posedge clk) hot_n <= 1'b0;
    repeat (3) @(posedge clk);
    u_host.read_reg(ADDR_TIMER, d);
    rc(ADDR_TIMER, 8'h01);
    u_host.write_reg(ADDR_PIN_FULL_SPEED_ON_HOT, 8'h06);
    fs(8'h00, 1'b0, 1'b0, 1'b0);
    fs(8'($urandom_range(255, 1)), 1'b0, 1'b0, 1'b1);
    fs(8'h00, 1'b1, 1'b1, 1'b1);
    fs(8'h80, 1'b1, 1'b0, 1'b0);
    @(posedge clk) hot_n <= 1'b1;
    repeat (3) @(posedge clk);
    fs(8'h80, 1'b0, 1'b0, 1'b0);
    u_host.read_reg(ADDR_TIMER, d);
    u_host.read_reg(ADDR_STATUS_ONE, d);
    u_host.write_reg(ADDR_PIN_FUNC, {6'h00, FUNC_HOT});
    hot(6, 1'b1);
    u_host.read_timer(d, st);
    chk(d, texp(6), "pin14 timer");
    chk(st, 8'h20, "timer limit flag");
    u_host.write_reg(ADDR_PIN_FULL_SPEED_ON_HOT, 8'h00);
    hot(6, 1'b1);
    rc(ADDR_TIMER, 8'h00);
    $display("test hot timer done");
    u_host.write_reg(ADDR_PIN_FUNC, 8'h00);
    @(posedge clk) vsel <= 1'b1;
    repeat (4) @(posedge clk);
    voltage_identification_inputs <= 6'($urandom_range(63, 1));
    repeat (5) @(posedge clk);
    rc(ADDR_STATUS_TWO, 8'h01);
    rc(ADDR_STATUS_TWO, 8'h00);
    $display("test vid change done");
    report_and_stop();
  end
endmodule
